/* File: rtl/program_entry_and_origin_counter.sv */
// command handling for origin counter and program entry mode
`timescale 1ns/100ps

module program_entry_and_origin_counter
	import entry_pkg::*;
(
	input  wire logic              i_clock,
	input  wire logic              i_sys_rst,
	input  wire logic              i_hard_reset,
	input  wire logic              i_escape,
	input  wire logic              i_backspace,
	input  wire logic              i_line_end,
	input  wire logic              i_axis_match,
	input  wire logic              i_multi_axis,
	input  wire logic [7:0]        i_axis_name,
	input  wire logic              i_cmd_valid,
	input  wire logic [7:0]        i_cmd_char,
	input  wire logic              i_cmd_has_data,
	input  wire logic [31:0]       i_cmd_data,
	input  wire logic              i_step,
	input  wire logic              i_step_up,
	output logic [31:0]            o_position,
	output logic                   o_prog_mode,
	output logic                   o_prompt_valid,
	output logic [11:0]            o_prompt_addr,
	output logic                   o_echo_valid,
	output logic [7:0]             o_echo_axis,
	output logic [7:0]             o_echo_cmd,
	output logic                   o_reject,
	output logic                   o_mem_we,
	output logic [9:0]             o_mem_addr,
	output logic [7:0]             o_mem_char,
	output logic [31:0]            o_mem_data,
	output logic                   o_run_valid,
	output logic [11:0]            o_run_addr,
	output logic                   o_nv_save,
	output logic                   o_nv_restore,
	output logic                   o_home_inv,
	output logic                   o_limit_inv,
	output logic                   o_report_valid,
	output logic                   o_report_kind,
	output logic [31:0]            o_report_value
);

	// ---------------------------------------------------------------
	// helper functions
	// ---------------------------------------------------------------
	function automatic logic [3:0] cmd_size(input logic [7:0] c);
		unique case (c)
			CH_ORIGIN: cmd_size = SZ_ORIGIN;
			CH_REL:    cmd_size = SZ_REL;
			CH_LOOP:   cmd_size = SZ_LOOP;
			CH_MOVE:   cmd_size = SZ_MOVE;
			CH_POL:    cmd_size = SZ_POL;
			default:   cmd_size = SZ_OTHER;
		endcase
	endfunction

	function automatic logic prog_char_ok(input logic [7:0] c);
		prog_char_ok = (c == CH_ORIGIN) || (c == CH_REL)
			|| (c == CH_LOOP) || (c == CH_MOVE)
			|| (c == CH_POL) || (c == CH_PLUS)
			|| (c == CH_MINUS) || (c == CH_STOP)
			|| (c == CH_WAIT) || (c == CH_RAMP)
			|| (c == CH_RUN) || (c == CH_SAVE);
	endfunction

	// addresses held in 12 bits; larger values saturate
	function automatic logic [11:0] to_addr(input logic [31:0] v);
		if (v[31] || (v[30:12] != 19'h0_0000)) begin
			to_addr = ADDR_SAT;
		end else begin
			to_addr = v[11:0];
		end
	endfunction

	function automatic logic addr_storable(input logic [11:0] a);
		addr_storable = (a <= ADDR_TOP)
			&& !((a >= ADDR_GAP_LO) && (a <= ADDR_GAP_HI));
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	mode_e       mode_r;
	logic [31:0] pos_r;
	logic [11:0] entry_addr_r;
	logic [1:0]  pol_r;
	logic        armed_r;
	logic        started_r;
	logic        prompt_r;
	logic        echo_r;
	logic [7:0]  echo_axis_r;
	logic [7:0]  echo_cmd_r;
	logic        reject_r;
	logic        we_r;
	logic [9:0]  mem_addr_r;
	logic [7:0]  mem_char_r;
	logic [31:0] mem_data_r;
	logic        run_r;
	logic [11:0] run_addr_r;
	logic        save_r;
	logic        restore_r;
	logic        rep_r;
	logic        rep_kind_r;
	logic [31:0] rep_val_r;

	// ---------------------------------------------------------------
	// command decode
	// ---------------------------------------------------------------
	wire         in_prog    = (mode_r == MODE_PROG);
	wire         single     = !i_multi_axis;
	// a multi axis line counts only after its axis name
	wire         line_ok    = single || armed_r || i_axis_match;
	wire         cmd        = i_cmd_valid && line_ok;
	wire         is_prog_ch = (i_cmd_char == CH_PROG);
	wire         imm_cmd    = cmd && !in_prog;
	wire         prg_cmd    = cmd && in_prog && !is_prog_ch;
	wire [31:0]  data_or_0  = i_cmd_has_data ? i_cmd_data : POS_RESET;

	wire do_origin = imm_cmd && (i_cmd_char == CH_ORIGIN);
	wire do_read   = imm_cmd && (i_cmd_char == CH_READ);
	wire do_run    = imm_cmd && (i_cmd_char == CH_RUN);
	wire do_save   = imm_cmd && (i_cmd_char == CH_SAVE)
		&& i_cmd_has_data && (i_cmd_data == SAVE_PROGS);
	wire do_pol    = imm_cmd && (i_cmd_char == CH_POL);
	wire pol_set   = do_pol && i_cmd_has_data;
	wire pol_ask   = do_pol && !i_cmd_has_data;
	wire do_enter  = imm_cmd && is_prog_ch;
	wire do_leave  = (cmd && in_prog && is_prog_ch)
		|| (in_prog && i_escape) || i_hard_reset;

	wire valid_ch  = prog_char_ok(i_cmd_char);
	wire storable  = addr_storable(entry_addr_r);
	wire do_store  = prg_cmd && valid_ch && storable;
	wire do_reject = prg_cmd && !valid_ch;
	wire do_bksp   = in_prog && i_backspace;

	wire [11:0] enter_addr = to_addr(data_or_0);
	wire [12:0] adv_sum    = {1'b0, entry_addr_r}
		+ {9'h000, cmd_size(i_cmd_char)};
	wire [11:0] adv_addr   = adv_sum[12] ? ADDR_SAT : adv_sum[11:0];

	wire [31:0] step_pos   = i_step_up ? (pos_r + 32'h0000_0001)
		: (pos_r - 32'h0000_0001);

	// prompt only in single axis mode
	wire want_prompt = single && (do_enter || do_store
		|| do_reject || do_bksp || (prg_cmd && valid_ch));

	// ---------------------------------------------------------------
	// position counter
	// ---------------------------------------------------------------
	// load wins over a coincident step; the motion engine keeps its
	// own remaining distance, so a load never alters a move
	always_ff @(posedge i_clock) begin
		if (i_sys_rst || i_hard_reset) begin
			pos_r <= POS_RESET;
		end else if (do_origin) begin
			pos_r <= data_or_0;
		end else if (i_step) begin
			pos_r <= step_pos;
		end
	end

	// ---------------------------------------------------------------
	// mode and entry address
	// ---------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			mode_r       <= MODE_IMM;
			entry_addr_r <= ADDR_START;
		end else if (do_leave) begin
			mode_r       <= MODE_IMM;
		end else if (do_enter) begin
			mode_r       <= MODE_PROG;
			entry_addr_r <= enter_addr;
		end else if (do_store) begin
			entry_addr_r <= adv_addr;
		end
	end

	// axis name stays armed across invalid chars and backspace;
	// a fresh name beats a same-cycle line end so it is not lost
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			armed_r <= 1'b0;
		end else if (i_axis_match) begin
			armed_r <= 1'b1;
		end else if (i_line_end || i_escape) begin
			armed_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// program memory write port
	// ---------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			we_r       <= 1'b0;
			mem_addr_r <= 10'h000;
			mem_char_r <= CH_NONE;
			mem_data_r <= POS_RESET;
		end else begin
			we_r <= do_store;
			if (do_store) begin
				mem_addr_r <= entry_addr_r[9:0];
				mem_char_r <= i_cmd_char;
				mem_data_r <= i_cmd_data;
			end
		end
	end

	// ---------------------------------------------------------------
	// console feedback
	// ---------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			prompt_r    <= 1'b0;
			echo_r      <= 1'b0;
			echo_axis_r <= CH_NONE;
			echo_cmd_r  <= CH_NONE;
			reject_r    <= 1'b0;
		end else begin
			prompt_r <= want_prompt;
			reject_r <= do_reject;
			echo_r   <= i_multi_axis && (do_store || do_bksp);
			echo_axis_r <= i_axis_name;
			// backspace echoes the axis name alone
			echo_cmd_r  <= do_bksp ? CH_NONE : i_cmd_char;
		end
	end

	// prompt shows the address the next command will go to
	wire [11:0] prompt_nxt = do_enter ? enter_addr
		: (do_store ? adv_addr : entry_addr_r);

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_prompt_addr <= ADDR_START;
		end else if (want_prompt) begin
			o_prompt_addr <= prompt_nxt;
		end
	end

	// ---------------------------------------------------------------
	// run, save, restore, polarity, reports
	// ---------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			run_r      <= 1'b0;
			run_addr_r <= ADDR_START;
			save_r     <= 1'b0;
		end else begin
			run_r  <= do_run;
			save_r <= do_save;
			if (do_run) begin
				run_addr_r <= enter_addr;
			end
		end
	end

	// one restore pulse on the first edge after reset release
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			started_r <= 1'b0;
			restore_r <= 1'b0;
		end else begin
			started_r <= 1'b1;
			restore_r <= !started_r;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			pol_r <= POL_RESET;
		end else if (pol_set) begin
			pol_r <= i_cmd_data[1:0];
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			rep_r      <= 1'b0;
			rep_kind_r <= REP_POS;
			rep_val_r  <= POS_RESET;
		end else begin
			rep_r <= do_read || pol_ask;
			if (do_read) begin
				rep_kind_r <= REP_POS;
				rep_val_r  <= pos_r;
			end else if (pol_ask) begin
				rep_kind_r <= REP_POL;
				rep_val_r  <= {30'h0000_0000, pol_r};
			end
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign o_position     = pos_r;
	assign o_prog_mode    = mode_r;
	assign o_prompt_valid = prompt_r;
	assign o_echo_valid   = echo_r;
	assign o_echo_axis    = echo_axis_r;
	assign o_echo_cmd     = echo_cmd_r;
	assign o_reject       = reject_r;
	assign o_mem_we       = we_r;
	assign o_mem_addr     = mem_addr_r;
	assign o_mem_char     = mem_char_r;
	assign o_mem_data     = mem_data_r;
	assign o_run_valid    = run_r;
	assign o_run_addr     = run_addr_r;
	assign o_nv_save      = save_r;
	assign o_nv_restore   = restore_r;
	assign o_home_inv     = pol_r[POL_HOME_BIT];
	assign o_limit_inv    = pol_r[POL_LIM_BIT];
	assign o_report_valid = rep_r;
	assign o_report_kind  = rep_kind_r;
	assign o_report_value = rep_val_r;

endmodule

/* File: rtl/entry_pkg.sv */
// constants for the program entry and origin counter block
package entry_pkg;
	localparam int POS_W    = 32;
	localparam int ADDR_W   = 12;
	localparam int CHAR_W   = 8;
	localparam int SIZE_W   = 4;
	// console characters
	localparam logic [7:0] CH_ORIGIN = 8'h4F;
	localparam logic [7:0] CH_PROG   = 8'h50;
	localparam logic [7:0] CH_READ   = 8'h5A;
	localparam logic [7:0] CH_RUN    = 8'h47;
	localparam logic [7:0] CH_SAVE   = 8'h53;
	localparam logic [7:0] CH_POL    = 8'h70;
	localparam logic [7:0] CH_PLUS   = 8'h2B;
	localparam logic [7:0] CH_MINUS  = 8'h2D;
	localparam logic [7:0] CH_STOP   = 8'h40;
	localparam logic [7:0] CH_LOOP   = 8'h4C;
	localparam logic [7:0] CH_MOVE   = 8'h4D;
	localparam logic [7:0] CH_REL    = 8'h52;
	localparam logic [7:0] CH_WAIT   = 8'h57;
	localparam logic [7:0] CH_RAMP   = 8'h4B;
	localparam logic [7:0] CH_NONE   = 8'h00;
	// stored sizes of commands
	localparam logic [3:0] SZ_ORIGIN = 4'h5;
	localparam logic [3:0] SZ_REL    = 4'h5;
	localparam logic [3:0] SZ_LOOP   = 4'h4;
	localparam logic [3:0] SZ_MOVE   = 4'h3;
	localparam logic [3:0] SZ_POL    = 4'h2;
	localparam logic [3:0] SZ_OTHER  = 4'h5;
	// program memory map
	localparam logic [11:0] ADDR_START   = 12'h000;
	localparam logic [11:0] ADDR_GAP_LO  = 12'h0C8;
	localparam logic [11:0] ADDR_GAP_HI  = 12'h0FF;
	localparam logic [11:0] ADDR_TOP     = 12'h3FF;
	localparam logic [11:0] ADDR_SAT     = 12'hFFF;
	localparam logic [31:0] POS_RESET    = 32'h0000_0000;
	localparam logic [31:0] SAVE_PROGS   = 32'h0000_0001;
	localparam logic [1:0]  POL_RESET    = 2'h0;
	localparam int          POL_HOME_BIT = 1;
	localparam int          POL_LIM_BIT  = 0;
	localparam logic        REP_POS      = 1'b0;
	localparam logic        REP_POL      = 1'b1;
	typedef enum logic {
		MODE_IMM  = 1'b0,
		MODE_PROG = 1'b1
	} mode_e;
endpackage

/* File: bench/host.sv */
// console host model driving parsed command lines
`timescale 1ns/100ps
module host (
	input  wire logic        i_clock,
	input  wire logic        i_multi_axis,
	output logic             o_hard_reset,
	output logic             o_escape,
	output logic             o_backspace,
	output logic             o_line_end,
	output logic             o_axis_match,
	output logic             o_cmd_valid,
	output logic [7:0]       o_cmd_char,
	output logic             o_cmd_has_data,
	output logic [31:0]      o_cmd_data
);
	initial begin
		{o_hard_reset, o_escape, o_backspace, o_line_end} = 4'h0;
		{o_axis_match, o_cmd_valid, o_cmd_has_data} = 3'h0;
		o_cmd_char = 8'h00;
		o_cmd_data = 32'h0;
	end
	// released char and data show junk, never the old value
	task automatic send(input logic [7:0] c, input logic h,
		input logic [31:0] d);
		@(negedge i_clock);
		o_axis_match = i_multi_axis;
		o_cmd_valid = 1'b1;
		o_cmd_char = c;
		o_cmd_has_data = h;
		o_cmd_data = d;
		@(negedge i_clock);
		{o_axis_match, o_cmd_valid} = 2'h0;
		o_cmd_char = ~c;
		o_cmd_data = ~d;
	endtask
	// k: 0 hard reset, 1 escape, 2 backspace, 3 line end
	task automatic key(input int k);
		@(negedge i_clock);
		{o_hard_reset, o_escape, o_backspace, o_line_end} = 4'h8 >> k;
		@(negedge i_clock);
		{o_hard_reset, o_escape, o_backspace, o_line_end} = 4'h0;
	endtask
endmodule

/* File: bench/ent_chk_assertions.sv */
// port assertions for the entry and origin counter block
`timescale 1ns/100ps
module ent_chk
	import entry_pkg::*;
(
	input wire logic        i_clock,
	input wire logic        i_sys_rst,
	input wire logic        i_hard_reset,
	input wire logic        i_escape,
	input wire logic        i_multi_axis,
	input wire logic        i_cmd_valid,
	input wire logic [7:0]  i_cmd_char,
	input wire logic        i_cmd_has_data,
	input wire logic [31:0] i_cmd_data,
	input wire logic        i_step,
	input wire logic        i_step_up,
	input wire logic [31:0] o_position,
	input wire logic        o_prog_mode,
	input wire logic        o_prompt_valid,
	input wire logic [11:0] o_prompt_addr,
	input wire logic        o_mem_we,
	input wire logic        o_nv_restore
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	wire imm = i_cmd_valid && !i_multi_axis && !o_prog_mode && !i_hard_reset;
	wire org = imm && i_cmd_char == CH_ORIGIN;
	wire ent = imm && i_cmd_char == CH_PROG && i_cmd_data < 32'h1000;
	wire mot = i_step && !i_cmd_valid && !i_hard_reset;
	wire lo  = o_prompt_addr >= ADDR_GAP_LO && o_prompt_addr <= ADDR_GAP_HI;
	wire gap = lo || o_prompt_addr > ADDR_TOP;
	AST_ORIGIN: assert property (org |=> o_position ==
		($past(i_cmd_has_data) ? $past(i_cmd_data) : POS_RESET))
		else $error("origin load wrong");
	AST_STEP: assert property (mot |=> o_position ==
		$past(o_position) + ($past(i_step_up) ? 32'h1 : 32'hFFFF_FFFF))
		else $error("step count wrong");
	AST_HOLD: assert property (!i_step && !i_cmd_valid &&
		!i_hard_reset |=> $stable(o_position))
		else $error("counter moved alone");
	AST_HARD: assert property (i_hard_reset |=>
		o_position == POS_RESET && !o_prog_mode)
		else $error("hard reset missed");
	AST_ENTER: assert property (ent |=> o_prog_mode &&
		o_prompt_valid && o_prompt_addr == ($past(i_cmd_has_data) ?
		$past(i_cmd_data[11:0]) : ADDR_START)) else $error("entry wrong");
	AST_EXIT: assert property (i_escape && o_prog_mode &&
		!i_cmd_valid |=> !o_prog_mode) else $error("escape missed");
	AST_GAP: assert property (o_prog_mode && i_cmd_valid &&
		!i_multi_axis && gap |=> !o_mem_we) else $error("gap stored");
	AST_PROMPT: assert property (o_prompt_valid |->
		!$past(i_multi_axis)) else $error("prompt in multi axis");
	AST_RESTORE: assert property ($fell(i_sys_rst) |=>
		o_nv_restore ##1 !o_nv_restore) else $error("restore wrong");
	cover property (ent);
	cover property (o_mem_we);
	cover property (mot && o_position == 32'h7FFF_FFFF);
endmodule
bind program_entry_and_origin_counter ent_chk ent_chk_i (
	.i_clock, .i_sys_rst, .i_hard_reset, .i_escape, .i_multi_axis,
	.i_cmd_valid, .i_cmd_char, .i_cmd_has_data, .i_cmd_data, .i_step,
	.i_step_up, .o_position, .o_prog_mode, .o_prompt_valid,
	.o_prompt_addr, .o_mem_we, .o_nv_restore
);

/* File: bench/tb_program_entry_and_origin_counter.sv */
// bench for the program entry and origin counter block
`timescale 1ns/100ps
module tb_program_entry_and_origin_counter
	import entry_pkg::*;
;
	logic i_clock, i_sys_rst, i_step, i_step_up, i_multi_axis;
	logic i_hard_reset, i_escape, i_backspace, i_line_end, i_axis_match;
	logic i_cmd_valid, i_cmd_has_data, o_prog_mode, o_prompt_valid;
	logic [7:0] i_cmd_char, i_axis_name, o_echo_axis, o_echo_cmd, o_mem_char;
	logic [31:0] i_cmd_data, o_position, o_mem_data, o_report_value;
	logic [11:0] o_prompt_addr, o_run_addr;
	logic [9:0] o_mem_addr;
	logic o_echo_valid, o_reject, o_mem_we, o_run_valid, o_nv_save;
	logic o_nv_restore, o_home_inv, o_limit_inv, o_report_valid;
	logic o_report_kind;
	int n_errors = 0;
	int n_compared = 0;
	typedef struct packed {
		logic [7:0] c; logic h; logic [31:0] d; logic [31:0] pos;
		logic rv; logic [31:0] val; logic [1:0] pol;
	} row_s;
	row_s rows [6] = '{
		'{CH_ORIGIN, 1'b1, 32'h7FFF_FFFF, 32'h7FFF_FFFF, 1'b0, 32'h0, 2'h0},
		'{CH_READ, 1'b0, 32'h0, 32'h7FFF_FFFF, 1'b1, 32'h7FFF_FFFF, 2'h0},
		'{CH_ORIGIN, 1'b0, 32'h5, 32'h0, 1'b0, 32'h0, 2'h0},
		'{CH_ORIGIN, 1'b1, 32'h8000_0000, 32'h8000_0000, 1'b0, 32'h0, 2'h0},
		'{CH_POL, 1'b1, 32'h2, 32'h8000_0000, 1'b0, 32'h0, 2'h2},
		'{CH_POL, 1'b0, 32'h0, 32'h8000_0000, 1'b1, 32'h2, 2'h2}
	};
	logic [31:0] gaps [4] = '{32'hC8, 32'hFF, 32'h100, 32'h400};
	program_entry_and_origin_counter program_entry_and_origin_counter_i (.*);
	host host_i (.i_clock, .i_multi_axis, .o_hard_reset(i_hard_reset),
		.o_escape(i_escape), .o_backspace(i_backspace),
		.o_line_end(i_line_end), .o_axis_match(i_axis_match),
		.o_cmd_valid(i_cmd_valid), .o_cmd_char(i_cmd_char),
		.o_cmd_has_data(i_cmd_has_data), .o_cmd_data(i_cmd_data));
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic results();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic step(input logic up);
		@(negedge i_clock);
		{i_step, i_step_up} = {1'b1, up};
		@(negedge i_clock);
		i_step = 1'b0;
	endtask
	task automatic rst();
		i_sys_rst = 1'b1;
		repeat (5) @(negedge i_clock);
		i_sys_rst = 1'b0;
		@(negedge i_clock);
		cmp({o_nv_restore, o_prog_mode}, 2'h2);
		cmp(o_position, POS_RESET);
	endtask
	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end
	// a hung sequence ends the run as a failure
	initial begin
		repeat (3000) @(posedge i_clock);
		n_errors++;
		results();
	end
	initial begin
		{i_step, i_step_up, i_multi_axis} = 3'h0;
		i_axis_name = 8'h41;
		rst();
		foreach (rows[k]) begin
			host_i.send(rows[k].c, rows[k].h, rows[k].d);
			cmp(o_position, rows[k].pos);
			cmp(o_report_valid, rows[k].rv);
			cmp({o_home_inv, o_limit_inv}, rows[k].pol);
			if (rows[k].rv) begin
				cmp(o_report_value, rows[k].val);
				cmp(o_report_kind, rows[k].c == CH_POL);
			end
		end
		step(1'b0);
		cmp(o_position, 32'h7FFF_FFFF);
		step(1'b1);
		cmp(o_position, 32'h8000_0000);
		host_i.key(0);
		cmp(o_position, POS_RESET);
		// load and step on one edge: the load wins
		fork
			step(1'b1);
			host_i.send(CH_ORIGIN, 1'b1, 32'h10);
		join
		cmp(o_position, 32'h10);
		host_i.send(CH_RUN, 1'b1, 32'h12C);
		cmp({o_run_valid, o_run_addr}, {1'b1, 12'h12C});
		host_i.send(CH_SAVE, 1'b1, SAVE_PROGS);
		cmp(o_nv_save, 1'b1);
		host_i.send(CH_PROG, 1'b1, 32'h64);
		cmp({o_prog_mode, o_prompt_addr}, {1'b1, 12'h064});
		host_i.send(CH_ORIGIN, 1'b1, 32'h7);
		cmp({o_mem_we, o_mem_addr, o_mem_char}, 19'h4644F);
		cmp(o_mem_data, 32'h7);
		cmp(o_position, 32'h10);
		cmp(o_prompt_addr, 12'h064 + SZ_ORIGIN);
		host_i.send(8'h21, 1'b0, 32'h0);
		cmp({o_reject, o_mem_we, o_prompt_valid}, 3'h5);
		host_i.key(2);
		cmp({o_prompt_valid, o_prompt_addr}, {1'b1, 12'h069});
		host_i.send(CH_PROG, 1'b0, 32'h0);
		cmp(o_prog_mode, 1'b0);
		foreach (gaps[k]) begin
			host_i.send(CH_PROG, 1'b1, gaps[k]);
			host_i.send(CH_MOVE, 1'b1, 32'h5);
			cmp(o_mem_we, gaps[k] == 32'h100);
			host_i.key(1);
			cmp(o_prog_mode, 1'b0);
		end
		i_multi_axis = 1'b1;
		host_i.send(CH_PROG, 1'b0, 32'h0);
		cmp({o_prog_mode, o_prompt_valid}, 2'h2);
		host_i.send(CH_MOVE, 1'b1, 32'h5);
		cmp({o_echo_valid, o_echo_axis, o_echo_cmd}, 17'h1414D);
		cmp({o_mem_we, o_mem_addr}, 11'h400);
		host_i.key(2);
		cmp({o_echo_valid, o_echo_cmd}, 9'h100);
		host_i.send(8'h21, 1'b0, 32'h0);
		cmp({o_reject, o_mem_we, o_prompt_valid}, 3'h4);
		host_i.send(CH_MOVE, 1'b1, 32'h5);
		cmp({o_mem_we, o_mem_addr}, 11'h403);
		host_i.key(1);
		i_multi_axis = 1'b0;
		rst();
		results();
	end
endmodule
